// ===== mfio_defs.svh
// Offsets, field positions and reset values of the multifunction I/O block.
// Included by the package and the port block module; definitions only.
`ifndef MFIO_DEFS_SVH
`define MFIO_DEFS_SVH

`define MFIO_NUM_PORTS      6
`define MFIO_PORT_A         3'h0
`define MFIO_PORT_B         3'h1
`define MFIO_PORT_C         3'h2
`define MFIO_PORT_D         3'h3
`define MFIO_PORT_E         3'h4
`define MFIO_PORT_G         3'h5
`define MFIO_ADDR_KIND_HI   6
`define MFIO_ADDR_KIND_LO   4
`define MFIO_ADDR_PORT_HI   2
`define MFIO_ADDR_PORT_LO   0
`define MFIO_KIND_IN        3'h0
`define MFIO_KIND_OUT       3'h1
`define MFIO_KIND_DIR       3'h2
`define MFIO_KIND_DRV       3'h3
`define MFIO_KIND_OE        3'h4
`define MFIO_RST_OUT        8'h00
`define MFIO_RST_DIR        8'h00
`define MFIO_RST_DRV        8'h00
`define MFIO_JTAG_TDO_BIT   3
`define MFIO_PORT_D_MASK    8'h0F

`endif

// ===== mfio_pkg.sv
// Types shared by the multifunction I/O block.
// Assumes mfio_defs.svh is on the include path.
`include "mfio_defs.svh"

package mfio_pkg;

    typedef enum logic [2:0]
    {
        MFIO_REG_IN  = 3'b000,
        MFIO_REG_OUT = 3'b001,
        MFIO_REG_DIR = 3'b010,
        MFIO_REG_DRV = 3'b011,
        MFIO_REG_OE  = 3'b100
    } mfio_reg_kind_t;

    typedef struct packed
    {
        logic [5:0][7:0] dout;
        logic [5:0][7:0] dir;
        logic [5:0][7:0] drv;
        logic [7:0]      rdata;
        logic            wr_n_prev;
    } mfio_state_t;

endpackage

// ===== mfio_pin_cell.sv
// Output multiplexer and driver control of one eight-pin port.
// Purely combinational; the caller owns all registers and the pin wire.
`timescale 1ns/1ps

module mfio_pin_cell #(
    parameter int W       = 8,
    parameter bit OD_CAPS = 1'b1
) (
    input  wire logic [W-1:0] dout_in,      // Output value register
    input  wire logic [W-1:0] dir_in,       // Direction register
    input  wire logic [W-1:0] drv_in,       // Drive select register
    input  wire logic [W-1:0] alt_sel_in,   // Pin owned by an array output
    input  wire logic [W-1:0] alt_data_in,  // Array output level
    input  wire logic [W-1:0] alt_oe_in,    // Array enable product term
    input  wire logic [W-1:0] force_in_in,  // Dedicated input function
    output logic      [W-1:0] pin_out,      // Pin output level
    output logic      [W-1:0] pin_oe_out    // Pin driver enable
);

    initial
    begin
        if (W < 1 || W > 8)
            $error("mfio_pin_cell: width out of range");
    end

    logic [W-1:0] level;
    logic [W-1:0] enable;
    logic [W-1:0] od_mode;

    always_comb
    begin
        level   = (alt_sel_in & alt_data_in) | (~alt_sel_in & dout_in);
        enable  = (alt_oe_in | dir_in) & ~force_in_in;
        od_mode = OD_CAPS ? drv_in : '0;
        // Open drain never drives high; the board pull-up does
        pin_out    = level & ~od_mode;
        pin_oe_out = enable & ~(od_mode & level);
    end

endmodule

// ===== mfio_port_block.sv
// Register block of the multifunction I/O ports, seen by the processor.
// Assumes the processor strobes are synchronous to SYS_CLK_IN and that the
// pin wires are resolved outside from the driver enables.
`timescale 1ns/1ps
`include "mfio_defs.svh"

module mfio_port_block (
    input  wire logic       SYS_CLK_IN,     // System clock
    input  wire logic       RST_N_IN,       // Async reset, active low
    input  wire logic       REG_SEL_IN,     // Register block decode select
    input  wire logic       RD_N_IN,        // Read strobe, active low
    input  wire logic       WR_N_IN,        // Write strobe, active low
    input  wire logic [7:0] ADDR_IN,        // Register address
    input  wire logic       BUS16_IN,       // 16-bit data configuration
    input  wire logic [7:0] PORT_F_IN,      // Data D7..D0 pin level
    output logic      [7:0] PORT_F_OUT,     // Data D7..D0 drive level
    output logic      [7:0] PORT_F_OE_OUT,  // Data D7..D0 driver enable
    input  wire logic [7:0] PORT_A_IN,      // Port A pin level
    output logic      [7:0] PORT_A_OUT,     // Port A drive level
    output logic      [7:0] PORT_A_OE_OUT,  // Port A driver enable
    input  wire logic [7:0] PORT_B_IN,      // Port B pin level
    output logic      [7:0] PORT_B_OUT,     // Port B drive level
    output logic      [7:0] PORT_B_OE_OUT,  // Port B driver enable
    input  wire logic [7:0] PORT_C_IN,      // Port C pin level
    output logic      [7:0] PORT_C_OUT,     // Port C drive level
    output logic      [7:0] PORT_C_OE_OUT,  // Port C driver enable
    output logic      [7:0] SLEW_FAST_C_OUT,// Port C fast slew select
    input  wire logic [3:0] PORT_D_IN,      // Port D pin level
    output logic      [3:0] PORT_D_OUT,     // Port D drive level
    output logic      [3:0] PORT_D_OE_OUT,  // Port D driver enable
    input  wire logic [7:0] PORT_E_IN,      // Port E pin level
    output logic      [7:0] PORT_E_OUT,     // Port E drive level
    output logic      [7:0] PORT_E_OE_OUT,  // Port E driver enable
    input  wire logic [7:0] PORT_G_IN,      // Port G pin level
    output logic      [7:0] PORT_G_OUT,     // Port G drive level
    output logic      [7:0] PORT_G_OE_OUT,  // Port G driver enable
    input  wire logic [7:0] CELL_A_SEL_IN,  // Port A pins owned by group A cells
    input  wire logic [7:0] CELL_A_DATA_IN, // Group A output cells
    input  wire logic [7:0] CELL_A_OE_IN,   // Group A enable terms
    input  wire logic [7:0] CELL_B_SEL_IN,  // Port B pins owned by group B cells
    input  wire logic [7:0] CELL_B_DATA_IN, // Group B output cells
    input  wire logic [7:0] CELL_B_OE_IN,   // Group B enable terms
    input  wire logic [7:0] ECS_SEL_IN,     // Port C pins owned by chip selects
    input  wire logic [7:0] ECS_DATA_IN,    // External chip selects
    input  wire logic [7:0] ECS_OE_IN,      // Chip select enable terms
    input  wire logic       LOGIC_CLOCK_INPUT_EN_IN,    // Port D pin 1 is logic clock
    input  wire logic       DEVSEL_EN_IN,   // Port D pin 2 is device select
    input  wire logic       WRH_EN_IN,      // Port D pin 3 is high-byte strobe
    input  wire logic       JTAG_ON_IN,     // Port E low pins are programming port
    input  wire logic       JTAG_TDO_IN,    // Programming port serial out
    input  wire logic       JTAG_TDO_OE_IN, // Programming port out enable
    output logic      [7:0] IMC_A_OUT,      // Port A levels to input macrocells
    output logic      [7:0] IMC_B_OUT,      // Port B levels to input macrocells
    output logic      [7:0] IMC_C_OUT,      // Port C levels to input macrocells
    output logic      [3:0] ARR_D_OUT,      // Port D levels straight to arrays
    output logic            LOGIC_CLK_OUT,  // Clock to macrocells and power-down
    output logic            DESELECT_OUT,   // Memories and registers disabled
    output logic            WR_HIGH_OUT,    // High-byte write strobe, active high
    output logic      [2:0] JTAG_IN_OUT     // TMS, TCK, TDI from port E
);

    localparam int NP = `MFIO_NUM_PORTS;

    initial
    begin
        if (`MFIO_JTAG_TDO_BIT > 7)
            $error("mfio_port_block: programming out bit out of range");
    end

    // Reset release through two flops
    logic rst_meta_ff;
    logic rst_sync_ff;

    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end
        else
        begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    mfio_pkg::mfio_state_t st_ff;
    mfio_pkg::mfio_state_t nxt_st;

    logic [NP-1:0][7:0] pin_lvl;
    logic [NP-1:0][7:0] alt_sel;
    logic [NP-1:0][7:0] alt_data;
    logic [NP-1:0][7:0] alt_oe;
    logic [NP-1:0][7:0] force_in;
    logic [NP-1:0][7:0] drv_eff;
    logic [NP-1:0][7:0] dir_eff;
    logic [NP-1:0][7:0] pin_o;
    logic [NP-1:0][7:0] pin_oe;
    logic               deselect;
    logic               bus_read;
    logic               bus_write;
    logic [2:0]         port_idx;
    logic [2:0]         kind;

    function automatic logic [7:0] port_mask(input logic [2:0] idx);
        port_mask = (idx == `MFIO_PORT_D) ? `MFIO_PORT_D_MASK : 8'hFF;
    endfunction

    assign deselect  = DEVSEL_EN_IN & PORT_D_IN[2];
    assign bus_read  = REG_SEL_IN & ~RD_N_IN & ~deselect;
    assign bus_write = REG_SEL_IN & ~WR_N_IN & st_ff.wr_n_prev & ~deselect;
    assign port_idx  = ADDR_IN[`MFIO_ADDR_PORT_HI:`MFIO_ADDR_PORT_LO];
    assign kind      = ADDR_IN[`MFIO_ADDR_KIND_HI:`MFIO_ADDR_KIND_LO];

    assign pin_lvl[0] = PORT_A_IN;
    assign pin_lvl[1] = PORT_B_IN;
    assign pin_lvl[2] = PORT_C_IN;
    assign pin_lvl[3] = {4'h0, PORT_D_IN};
    assign pin_lvl[4] = PORT_E_IN;
    assign pin_lvl[5] = PORT_G_IN;

    // Array sources per port
    always_comb
    begin
        alt_sel  = '0;
        alt_data = '0;
        alt_oe   = '0;
        force_in = '0;
        drv_eff  = st_ff.drv;
        dir_eff  = st_ff.dir;
        alt_sel[0]  = CELL_A_SEL_IN;
        alt_data[0] = CELL_A_DATA_IN;
        alt_oe[0]   = CELL_A_OE_IN;
        alt_sel[1]  = CELL_B_SEL_IN;
        alt_data[1] = CELL_B_DATA_IN;
        alt_oe[1]   = CELL_B_OE_IN;
        alt_sel[2]  = ECS_SEL_IN;
        alt_data[2] = ECS_DATA_IN;
        alt_oe[2]   = ECS_OE_IN;
        // Dedicated port D inputs never drive; upper four bits do not exist
        force_in[3] = {4'hF, WRH_EN_IN, DEVSEL_EN_IN, LOGIC_CLOCK_INPUT_EN_IN, 1'b0};
        if (JTAG_ON_IN)
        begin
            force_in[4][2:0]                  = 3'h7;
            alt_sel[4][`MFIO_JTAG_TDO_BIT]  = 1'b1;
            alt_data[4][`MFIO_JTAG_TDO_BIT] = JTAG_TDO_IN;
            alt_oe[4][`MFIO_JTAG_TDO_BIT]   = JTAG_TDO_OE_IN;
            drv_eff[4][`MFIO_JTAG_TDO_BIT]  = 1'b0;
        end
        if (BUS16_IN)
        begin
            // Port G is data D15..D8; registers are a byte wide, so it reads zero
            alt_sel[5]  = 8'hFF;
            alt_data[5] = 8'h00;
            alt_oe[5]   = {8{bus_read}};
            drv_eff[5]  = 8'h00;
            // Stale direction bits must not fight the high data byte
            dir_eff[5]  = 8'h00;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NP; gi++)
        begin : g_port
            mfio_pin_cell #(
                .W       (8),
                .OD_CAPS (gi != 2 && gi != 3)
            ) u_cell (
                .dout_in     (st_ff.dout[gi]),
                .dir_in      (dir_eff[gi]),
                .drv_in      (drv_eff[gi]),
                .alt_sel_in  (alt_sel[gi]),
                .alt_data_in (alt_data[gi]),
                .alt_oe_in   (alt_oe[gi]),
                .force_in_in (force_in[gi]),
                .pin_out     (pin_o[gi]),
                .pin_oe_out  (pin_oe[gi])
            );
        end
    endgenerate

    // Register read mux: pin level is live, not a stale sample
    function automatic logic [7:0] read_mux(
        input mfio_pkg::mfio_state_t s,
        input logic [NP-1:0][7:0]    lvl,
        input logic [NP-1:0][7:0]    oe,
        input logic [2:0]            k,
        input logic [2:0]            p
    );
        logic [7:0] v;
        v = 8'h00;
        if (p < 3'(NP))
        begin
            case (k)
                `MFIO_KIND_IN:  v = lvl[p];
                `MFIO_KIND_OUT: v = s.dout[p];
                `MFIO_KIND_DIR: v = s.dir[p];
                `MFIO_KIND_DRV: v = s.drv[p];
                `MFIO_KIND_OE:  v = oe[p];
                default:        v = 8'h00;
            endcase
        end
        read_mux = v & port_mask(p);
    endfunction

    always_comb
    begin
        nxt_st           = st_ff;
        nxt_st.wr_n_prev = WR_N_IN | ~REG_SEL_IN;
        if (bus_read)
            nxt_st.rdata = read_mux(st_ff, pin_lvl, pin_oe, kind, port_idx);
        // Port G registers are locked while it carries the high data byte
        if (bus_write && port_idx < 3'(NP) && !(BUS16_IN && port_idx == `MFIO_PORT_G))
        begin
            case (kind)
                `MFIO_KIND_OUT: nxt_st.dout[port_idx] = PORT_F_IN & port_mask(port_idx);
                `MFIO_KIND_DIR: nxt_st.dir[port_idx]  = PORT_F_IN & port_mask(port_idx);
                `MFIO_KIND_DRV: nxt_st.drv[port_idx]  = PORT_F_IN & port_mask(port_idx);
                default:        nxt_st.rdata = nxt_st.rdata;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK_IN or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
        begin
            st_ff.dout      <= {NP{`MFIO_RST_OUT}};
            st_ff.dir       <= {NP{`MFIO_RST_DIR}};
            st_ff.drv       <= {NP{`MFIO_RST_DRV}};
            st_ff.rdata     <= 8'h00;
            st_ff.wr_n_prev <= 1'b1;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // Port F is only ever the data bus
    assign PORT_F_OUT      = st_ff.rdata;
    assign PORT_F_OE_OUT   = {8{bus_read}};
    assign PORT_A_OUT      = pin_o[0];
    assign PORT_A_OE_OUT   = pin_oe[0];
    assign PORT_B_OUT      = pin_o[1];
    assign PORT_B_OE_OUT   = pin_oe[1];
    assign PORT_C_OUT      = pin_o[2];
    assign PORT_C_OE_OUT   = pin_oe[2];
    assign SLEW_FAST_C_OUT = st_ff.drv[2];
    assign PORT_D_OUT      = pin_o[3][3:0];
    assign PORT_D_OE_OUT   = pin_oe[3][3:0];
    assign PORT_E_OUT      = pin_o[4];
    assign PORT_E_OE_OUT   = pin_oe[4];
    assign PORT_G_OUT      = pin_o[5];
    assign PORT_G_OE_OUT   = pin_oe[5];
    assign IMC_A_OUT       = PORT_A_IN;
    assign IMC_B_OUT       = PORT_B_IN;
    assign IMC_C_OUT       = PORT_C_IN;
    assign ARR_D_OUT       = PORT_D_IN;
    assign LOGIC_CLK_OUT   = LOGIC_CLOCK_INPUT_EN_IN & PORT_D_IN[1];
    assign DESELECT_OUT    = deselect;
    assign WR_HIGH_OUT     = WRH_EN_IN & ~PORT_D_IN[3];
    assign JTAG_IN_OUT     = JTAG_ON_IN ? PORT_E_IN[2:0] : 3'h0;

    sequence s_write_dir;
        bus_write && kind == `MFIO_KIND_DIR && port_idx == `MFIO_PORT_A;
    endsequence

    sequence s_read_in;
        bus_read && kind == `MFIO_KIND_IN && port_idx == `MFIO_PORT_B;
    endsequence

    a_read_pin_level: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_sync_ff)
        s_read_in |=> PORT_F_OUT == $past(PORT_B_IN))
        else $error("pin level read wrong");

    a_dir_readback: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_sync_ff)
        s_write_dir ##1 (!bus_write)[*2] |-> st_ff.dir[0] == $past(PORT_F_IN, 2))
        else $error("direction readback wrong");

    a_dout_drives: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_sync_ff)
        st_ff.dir[0][0] && !CELL_A_SEL_IN[0] && !st_ff.drv[0][0]
        |-> PORT_A_OE_OUT[0] && PORT_A_OUT[0] == st_ff.dout[0][0])
        else $error("output value not on pin");

    a_array_wins: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_sync_ff)
        CELL_B_SEL_IN[1] && !st_ff.drv[1][1] |-> PORT_B_OUT[1] == CELL_B_DATA_IN[1])
        else $error("array output lost priority");

    a_oe_or_rule: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_sync_ff)
        !st_ff.drv[2][0] |-> PORT_C_OE_OUT[0] == (ECS_OE_IN[0] | st_ff.dir[2][0]))
        else $error("driver enable not OR of term and direction");

    a_open_drain: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_sync_ff)
        st_ff.drv[4][6] && !JTAG_ON_IN |-> !(PORT_E_OE_OUT[6] && PORT_E_OUT[6]))
        else $error("open drain drove high");

    a_reset_inputs: assert property (@(posedge SYS_CLK_IN)
        $rose(rst_sync_ff) |-> PORT_A_OE_OUT == (CELL_A_OE_IN & 8'hFF)
        && st_ff.dir == '0 && st_ff.drv == '0)
        else $error("pins not inputs after reset");

    a_status_matches: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_sync_ff)
        bus_read && kind == `MFIO_KIND_OE && port_idx == `MFIO_PORT_E
        |=> PORT_F_OUT == $past(PORT_E_OE_OUT))
        else $error("enable status mismatch");

    a_deselect_blocks: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_sync_ff)
        DEVSEL_EN_IN && PORT_D_IN[2] |-> !bus_write && PORT_F_OE_OUT == 8'h00
        && !PORT_D_OE_OUT[2])
        else $error("device select did not disable registers");

    a_bus16_port_g: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_sync_ff)
        BUS16_IN |-> PORT_G_OUT == 8'h00 && PORT_G_OE_OUT == {8{bus_read}})
        else $error("port G not data bus in 16-bit mode");

    a_clock_pin_input: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_sync_ff)
        LOGIC_CLOCK_INPUT_EN_IN |-> !PORT_D_OE_OUT[1] && LOGIC_CLK_OUT == PORT_D_IN[1])
        else $error("logic clock pin driven");

endmodule

// ===== mfio_pin_env.sv
// Board side of one port: peripherals that drive a pin while the device is off it.
// Assumes the bench supplies the peripheral levels on ext_in.
`timescale 1ns/1ps

module mfio_pin_env #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] dev_out_in, // Device drive level
    input  wire logic [W-1:0] dev_oe_in,  // Device driver enable
    input  wire logic [W-1:0] ext_in,     // Peripheral level
    output logic      [W-1:0] lvl_out     // Resolved pin level
);
    // Peripheral backs off wherever the device drives, so no contention
    assign lvl_out = (dev_oe_in & dev_out_in) | (~dev_oe_in & ext_in);
endmodule

// ===== testbench.sv
// Self-checking bench of the multifunction I/O port block.
// Assumes mfio_pin_env stands on the board side of every port except data port F.
`timescale 1ns/1ps

module testbench;
    logic       clk = 1'b0, rst_n = 1'b0, sel = 1'b0, rd_n = 1'b1, wr_n = 1'b1;
    logic       b16 = 1'b0, jon = 1'b0, tdo = 1'b0, toe = 1'b0;
    logic [2:0] dfn = 3'h0;
    logic [7:0] addr = 8'h00, fd = 8'h00;
    logic [7:0] ext [6] = '{default: 8'h00};
    logic [7:0] asl [3] = '{default: 8'h00};
    logic [7:0] adt [3] = '{default: 8'h00};
    logic [7:0] aoe [3] = '{default: 8'h00};
    logic [7:0] mr [4][6] = '{default: '{default: 8'h00}};
    wire  [7:0] po [6], pe [6], pl [6], input_macrocell [3];
    wire  [7:0] f_o, f_e, f_i, slew;
    wire  [3:0] d_o, d_e, ard;
    wire  [2:0] jin;
    wire        lclk, dsel, high_byte_write_strobe;
    int         n_errors = 0, num_checks = 0;

    always #5 clk = ~clk;
    // Data bus wire: device drives it only during a read
    assign f_i = (f_e & f_o) | (~f_e & fd);
    assign po[3] = {4'h0, d_o};
    assign pe[3] = {4'h0, d_e};
    for (genvar i = 0; i < 6; i++)
    begin : g_env
        mfio_pin_env env (.dev_out_in(po[i]), .dev_oe_in(pe[i]), .ext_in(ext[i]), .lvl_out(pl[i]));
    end

    mfio_port_block uut (
        .SYS_CLK_IN(clk), .RST_N_IN(rst_n), .REG_SEL_IN(sel), .RD_N_IN(rd_n), .WR_N_IN(wr_n),
        .ADDR_IN(addr), .BUS16_IN(b16), .PORT_F_IN(f_i), .PORT_F_OUT(f_o), .PORT_F_OE_OUT(f_e),
        .PORT_A_IN(pl[0]), .PORT_A_OUT(po[0]), .PORT_A_OE_OUT(pe[0]),
        .PORT_B_IN(pl[1]), .PORT_B_OUT(po[1]), .PORT_B_OE_OUT(pe[1]),
        .PORT_C_IN(pl[2]), .PORT_C_OUT(po[2]), .PORT_C_OE_OUT(pe[2]), .SLEW_FAST_C_OUT(slew),
        .PORT_D_IN(pl[3][3:0]), .PORT_D_OUT(d_o), .PORT_D_OE_OUT(d_e),
        .PORT_E_IN(pl[4]), .PORT_E_OUT(po[4]), .PORT_E_OE_OUT(pe[4]),
        .PORT_G_IN(pl[5]), .PORT_G_OUT(po[5]), .PORT_G_OE_OUT(pe[5]),
        .CELL_A_SEL_IN(asl[0]), .CELL_A_DATA_IN(adt[0]), .CELL_A_OE_IN(aoe[0]),
        .CELL_B_SEL_IN(asl[1]), .CELL_B_DATA_IN(adt[1]), .CELL_B_OE_IN(aoe[1]),
        .ECS_SEL_IN(asl[2]), .ECS_DATA_IN(adt[2]), .ECS_OE_IN(aoe[2]),
        .LOGIC_CLOCK_INPUT_EN_IN(dfn[0]), .DEVSEL_EN_IN(dfn[1]), .WRH_EN_IN(dfn[2]),
        .JTAG_ON_IN(jon), .JTAG_TDO_IN(tdo), .JTAG_TDO_OE_IN(toe),
        .IMC_A_OUT(input_macrocell[0]), .IMC_B_OUT(input_macrocell[1]), .IMC_C_OUT(input_macrocell[2]), .ARR_D_OUT(ard),
        .LOGIC_CLK_OUT(lclk), .DESELECT_OUT(dsel), .WR_HIGH_OUT(high_byte_write_strobe), .JTAG_IN_OUT(jin));

    task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("[ERR] %s exp %h got %h", w, e, g);
        end
    endtask

    // Model follows only writes the device should accept
    task automatic wr(input int k, input int p, input logic [7:0] d);
        @(posedge clk);
        sel <= 1'b1;
        wr_n <= 1'b0;
        addr <= 8'(k * 16 + p);
        fd <= d;
        @(posedge clk);
        sel <= 1'b0;
        wr_n <= 1'b1;
        if (k > 0 && k < 4 && p < 6 && !(b16 && p == 5) && !(dfn[1] && ext[3][2]))
            mr[k][p] = d & (p == 3 ? 8'h0F : 8'hFF);
    endtask

    task automatic rchk(input string w, input int k, input int p, input logic [7:0] e);
        @(posedge clk);
        sel <= 1'b1;
        rd_n <= 1'b0;
        addr <= 8'(k * 16 + p);
        #1;
        chk("bus drive", 8'hFF, f_e);
        @(posedge clk);
        sel <= 1'b0;
        rd_n <= 1'b1;
        #1;
        chk(w, e, f_o);
    endtask

    task automatic summarize();
        if (n_errors == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        logic [7:0] m, od, oe, lv;
        int p;
        void'($urandom(45));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (int k = 1; k < 5; k++)
            for (int i = 0; i < 6; i++)
                rchk("reset reg", k, i, 8'h00);
        repeat (40)
        begin
            p = $urandom % 6;
            for (int k = 1; k < 4; k++)
                wr(k, p, 8'($urandom));
            ext[p] <= 8'($urandom);
            @(negedge clk);
            m = p == 3 ? 8'h0F : 8'hFF;
            od = (p == 2 || p == 3) ? 8'h00 : 8'hFF;
            oe = mr[2][p] & ~(od & mr[3][p] & mr[1][p]) & m;
            lv = ((oe & mr[1][p]) | (~oe & ext[p])) & m;
            chk("pin oe", oe, pe[p]);
            chk("pin out", oe & mr[1][p], oe & po[p]);
            if (p < 3)
                chk("macrocell in", lv, input_macrocell[p]);
            if (p == 3)
                chk("direct in", lv, {4'h0, ard});
            if (p == 2)
                chk("slew", mr[3][2], slew);
            rchk("pin in", 0, p, lv);
            rchk("oe status", 4, p, oe);
            for (int k = 1; k < 4; k++)
                rchk("readback", k, p, mr[k][p]);
        end
        for (int i = 0; i < 3; i++)
        begin
            wr(3, i, 8'h00);
            wr(2, i, 8'($urandom));
            asl[i] <= 8'hFF;
            adt[i] <= 8'($urandom);
            aoe[i] <= 8'($urandom);
            wr(1, i, 8'($urandom));
            @(negedge clk);
            oe = aoe[i] | mr[2][i];
            chk("array oe", oe, pe[i]);
            chk("array out", oe & adt[i], oe & po[i]);
            rchk("array oe status", 4, i, oe);
            asl[i] <= 8'h00;
            aoe[i] <= 8'h00;
        end
        wr(2, 3, 8'h00);
        dfn <= 3'h7;
        ext[3] <= 8'h06;
        wr(1, 0, 8'h5A);
        @(negedge clk);
        chk("dedicated", 8'h07, {5'h0, lclk, dsel, high_byte_write_strobe});
        ext[3] <= 8'h08;
        @(negedge clk);
        chk("dedicated", 8'h00, {5'h0, lclk, dsel, high_byte_write_strobe});
        dfn <= 3'h0;
        rchk("deselected write", 1, 0, mr[1][0]);
        jon <= 1'b1;
        ext[4] <= 8'($urandom);
        tdo <= 1'b1;
        toe <= 1'b1;
        @(negedge clk);
        chk("prog port", {5'h0, ext[4][2:0]}, {5'h0, jin});
        chk("prog out", 8'h03, {6'h0, pe[4][3], po[4][3]});
        jon <= 1'b0;
        toe <= 1'b0;
        b16 <= 1'b1;
        wr(1, 5, 8'h3C);
        rchk("port g wide", 1, 5, mr[1][5]);
        chk("port g idle", 8'h00, pe[5] | po[5]);
        b16 <= 1'b0;
        rchk("port g narrow", 1, 5, mr[1][5]);
        rchk("port f", 1, 6, 8'h00);
        rchk("unmapped", 5, 0, 8'h00);
        summarize();
    end

    initial
    begin
        #200000;
        n_errors++;
        summarize();
    end
endmodule
